// ---- hdl/settle_timer.sv ----
`default_nettype none
module settle_timer #(
  parameter int CYCLES = 200
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic run,
  output logic      done
);
  typedef struct packed {
    logic [15:0] count;
    logic        done;
  } timer_state_t;
  timer_state_t s_r;
  timer_state_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (!run) begin
      s_nxt.count = 16'h0000;
      s_nxt.done  = 1'b0;
    end else if (!s_r.done) begin
      if (s_r.count == 16'(CYCLES - 1)) begin
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.count = s_r.count + 16'h0001;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign done = s_r.done;
endmodule
`default_nettype wire

// ---- hdl/supply_trip_detector.sv ----
// Notes on behaviour
// - the analog detector is powered only while detector_power_enable is one.
// - after each enabling, reference_stable_flag stays zero until settling ends, then goes one; an enable one cycle after a disable sets it for a cycle first.
// - no trip event is flagged while reference_stable_flag is zero.
// - direction one trips at or above the trip point, zero trips below it.
// - level 1111 selects the external input, 1110 the maximum, 0000 the minimum internal level.
// - a trip sets the event flag and raises the interrupt if enabled.
`default_nettype none
module supply_trip_detector #(
  parameter int SETTLE_CYCLES = trip_detector_pkg::SETTLE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  input  wire logic       cmp_at_or_above,
  input  wire logic       ext_at_or_above,
  output logic            analog_power_on,
  output logic [3:0]      analog_level,
  output logic            irq
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  typedef struct packed {
    logic [7:0]      control;
    logic [1:0]      status;
    logic [1:0]      mask;
    logic [7:0]      rdata;
    logic            stable_d;
  } det_state_t;
  det_state_t s_r;
  det_state_t s_nxt;
  logic stable;
  logic tripped;
  logic [1:0] ev;
  logic enabled;
  assign enabled = s_r.control[trip_detector_pkg::BIT_EN];
  settle_timer #(
    .CYCLES (SETTLE_CYCLES)
  ) u_timer (
    .mclk (mclk),
    .rst  (rst),
    .run  (enabled),
    .done (stable)
  );
  trip_compare u_cmp (
    .mclk            (mclk),
    .rst             (rst),
    .dir_rise        (s_r.control[trip_detector_pkg::BIT_DIR]),
    .level           (s_r.control[trip_detector_pkg::LEVEL_LSB +: trip_detector_pkg::LEVEL_W]),
    .cmp_at_or_above (cmp_at_or_above),
    .ext_at_or_above (ext_at_or_above),
    .tripped         (tripped)
  );
  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    s_nxt = s_r;
    ev = 2'b00;
    ev[trip_detector_pkg::EV_TRIP]   = enabled && stable && tripped;
    ev[trip_detector_pkg::EV_STABLE] = stable && !s_r.stable_d;
    s_nxt.stable_d = stable;
    // stable flag mirrors the timer, which restarts on every enable;
    // gated by the enable so it drops with the power bit, not a timer tick later
    s_nxt.control[trip_detector_pkg::BIT_STABLE] = stable && enabled;
    s_nxt.control[6] = 1'b0;
    if (wr) begin
      case (addr)
        trip_detector_pkg::ADDR_CONTROL: begin
          s_nxt.control = (wdata & trip_detector_pkg::CONTROL_WMASK)
                        | {2'b00, stable && wdata[trip_detector_pkg::BIT_EN], 5'h00};
        end
        trip_detector_pkg::ADDR_STATUS: begin
          s_nxt.status = s_r.status & ~wdata[1:0];
        end
        trip_detector_pkg::ADDR_MASK: begin
          s_nxt.mask = wdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // set wins over a clear in the same cycle
    s_nxt.status = s_nxt.status | ev;
    s_nxt.rdata = 8'h00;
    if (rd) begin
      case (addr)
        trip_detector_pkg::ADDR_CONTROL: s_nxt.rdata = s_r.control;
        trip_detector_pkg::ADDR_STATUS:  s_nxt.rdata = {6'h00, s_r.status};
        trip_detector_pkg::ADDR_MASK:    s_nxt.rdata = {6'h00, s_r.mask};
        default:                         s_nxt.rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r.control  <= trip_detector_pkg::CONTROL_RESET;
      s_r.status   <= 2'b00;
      s_r.mask     <= 2'b00;
      s_r.rdata    <= 8'h00;
      s_r.stable_d <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign analog_power_on = enabled;
  assign analog_level    = s_r.control[3:0];
  assign rdata           = s_r.rdata;
  assign irq             = |(s_r.status & s_r.mask);
endmodule
`default_nettype wire

// ---- hdl/trip_compare.sv ----
`default_nettype none
module trip_compare (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       dir_rise,
  input  wire logic [3:0] level,
  input  wire logic       cmp_at_or_above,
  input  wire logic       ext_at_or_above,
  output logic            tripped
);
  // ---------------------------------------------
  // level decode and direction
  // ---------------------------------------------
  typedef struct packed {
    logic tripped;
  } cmp_state_t;
  cmp_state_t s_r;
  cmp_state_t s_nxt;
  logic above;
  always_comb begin
    // code 1111 uses the external input comparator
    if (level == trip_detector_pkg::LEVEL_EXTERNAL) begin
      above = ext_at_or_above;
    end else begin
      above = cmp_at_or_above;
    end
    s_nxt.tripped = dir_rise ? above : !above;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign tripped = s_r.tripped;
endmodule
`default_nettype wire

// ---- pkg/trip_detector_pkg.sv ----
`default_nettype none
package trip_detector_pkg;
  // register offsets (plain port address)
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_MASK    = 4'h2;
  // control field positions
  localparam int BIT_DIR    = 7;
  localparam int BIT_STABLE = 5;
  localparam int BIT_EN     = 4;
  localparam int LEVEL_LSB  = 0;
  localparam int LEVEL_W    = 4;
  // reset values: direction 0, disabled, level 0101
  localparam logic [7:0] CONTROL_RESET = 8'h05;
  localparam logic [7:0] CONTROL_WMASK = 8'h9F;
  // status/mask layout
  localparam int EV_TRIP = 0;
  localparam int EV_STABLE = 1;
  localparam int EV_W = 2;
  // level codes
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
  localparam logic [3:0] LEVEL_MAX      = 4'hE;
  localparam logic [3:0] LEVEL_MIN      = 4'h0;
  // settling time
  localparam int SETTLE_NS = 20000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ---- verif/supply_trip_detector_tb_top.sv ----
`default_nettype none
module supply_trip_detector_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, cmp = 1'b0, ext = 1'b0, pwr, irq;
  logic [3:0] addr = 4'h0, lvl;
  logic [7:0] wdata = 8'h00, rdata;
  int         bad_count = 0, check_count = 0;
  always #50 mclk = ~mclk;
  supply_trip_detector #(.SETTLE_CYCLES(8)) dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cmp_at_or_above(cmp), .ext_at_or_above(ext),
    .analog_power_on(pwr), .analog_level(lvl), .irq(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(4'h0, 8'h05);
    rd_chk(4'h3, 8'h00);
    ext <= 1'b1;
    wr_reg(4'h0, 8'hDF);
    rd_chk(4'h0, 8'h9F);
    rd_chk(4'h1, 8'h00);
    chk({4'h0, lvl}, 8'h0F);
    chk({7'h00, pwr}, 8'h01);
    repeat (12) @(posedge mclk);
    rd_chk(4'h0, 8'hBF);
    rd_chk(4'h1, 8'h03);
    wr_reg(4'h2, 8'h01);
    rd_chk(4'h2, 8'h01);
    chk({7'h00, irq}, 8'h01);
    ext <= 1'b0;
    wr_reg(4'h1, 8'h03);
    rd_chk(4'h1, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr_reg(4'h0, 8'h1E);
    chk({4'h0, lvl}, 8'h0E);
    cmp <= 1'b1;
    wr_reg(4'h0, 8'h10);
    repeat (4) @(posedge mclk);
    rd_chk(4'h1, 8'h00);
    cmp <= 1'b0;
    repeat (4) @(posedge mclk);
    rd_chk(4'h1, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr_reg(4'h0, 8'h00);
    rd_chk(4'h0, 8'h00);
    chk({7'h00, pwr}, 8'h00);
    rd_chk(4'h1, 8'h01);
    wr_reg(4'h0, 8'h10);
    rd_chk(4'h0, 8'h10);
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- verif/trip_detector_chk.sv ----
`default_nettype none
module trip_detector_chk #(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       analog_power_on,
  input wire logic [3:0] analog_level,
  input wire logic       irq
);
  logic [7:0] cnt_r;
  // cycles since the detector was powered
  always_ff @(posedge mclk) begin
    if (rst || !analog_power_on) cnt_r <= 8'h00;
    else if (cnt_r != 8'hFF) cnt_r <= cnt_r + 8'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  pwr_follows_a: assert property (wr && addr == 4'h0 |=> analog_power_on == $past(wdata[4]))
    else $error("power enable wrong");
  level_follows_a: assert property (wr && addr == 4'h0 |=> analog_level == $past(wdata[3:0]))
    else $error("level wrong");
  level_hold_a: assert property (!(wr && addr == 4'h0) |=> $stable(analog_level))
    else $error("level moved");
  rsv_bit_a: assert property (rd && addr == 4'h0 |=> !rdata[6])
    else $error("reserved bit set");
  unmapped_rd_a: assert property (rd && addr > 4'h2 |=> rdata == 8'h00)
    else $error("unmapped read");
  stable_low_a: assert property (rd && addr == 4'h0 && cnt_r < SETTLE_CYCLES - 2 |=> !rdata[5])
    else $error("stable too early");
  stable_high_a: assert property (rd && addr == 4'h0 && cnt_r > SETTLE_CYCLES + 2 |=> rdata[5])
    else $error("stable missing");
  stable_clr_a: assert property (rd && addr == 4'h0 && !analog_power_on |=> !rdata[5])
    else $error("stable while off");
  irq_drop_a: assert property ($fell(irq) |-> $past(wr))
    else $error("irq dropped alone");
  cover property (wr && addr == 4'h1);
  cover property ($rose(irq));
  cover property (rd && addr == 4'h0 && cnt_r > SETTLE_CYCLES);
endmodule
bind supply_trip_detector trip_detector_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (.mclk(mclk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .analog_power_on(analog_power_on),
  .analog_level(analog_level), .irq(irq));
`default_nettype wire
